// *** core/color_bytes_pkg.sv ***
// Purpose: constants for the test pattern color byte bank
// Assumes: 32-bit word-aligned slave; offsets are indexes times four
// Notes: none
package color_bytes_pkg;
   localparam int NUM_REGS = 9;
   localparam int NUM_BARS = 8;
   localparam int BYTE_W   = 8;
   localparam int ADDR_W   = 8;
   // register indexes as printed; byte address is index times four
   localparam logic [7:0] IDX_BAR0  = 8'h10;
   localparam logic [7:0] IDX_BAR1  = 8'h11;
   localparam logic [7:0] IDX_BAR2  = 8'h12;
   localparam logic [7:0] IDX_BAR3  = 8'h13;
   localparam logic [7:0] IDX_BAR4  = 8'h14;
   localparam logic [7:0] IDX_BAR5  = 8'h15;
   localparam logic [7:0] IDX_BAR6  = 8'h16;
   localparam logic [7:0] IDX_BAR7  = 8'h17;
   localparam logic [7:0] IDX_BYTE9 = 8'h18;
   // values after reset, first to ninth
   localparam logic [7:0] RST_BAR0  = 8'haa;
   localparam logic [7:0] RST_BAR1  = 8'h33;
   localparam logic [7:0] RST_BAR2  = 8'hf0;
   localparam logic [7:0] RST_BAR3  = 8'h7f;
   localparam logic [7:0] RST_BAR4  = 8'h55;
   localparam logic [7:0] RST_BAR5  = 8'hcc;
   localparam logic [7:0] RST_BAR6  = 8'h0f;
   localparam logic [7:0] RST_BAR7  = 8'h80;
   localparam logic [7:0] RST_BYTE9 = 8'h00;
   localparam logic [7:0] RST_VAL [NUM_REGS] = '{RST_BAR0, RST_BAR1,
      RST_BAR2, RST_BAR3, RST_BAR4, RST_BAR5, RST_BAR6, RST_BAR7,
      RST_BYTE9};
   // pattern modes seen by the generator
   typedef enum logic [1:0] {
      MODE_OFF   = 2'b00,
      MODE_BARS  = 2'b01,
      MODE_FIXED = 2'b10
   } pat_mode_t;
endpackage

// *** core/color_if.sv ***
// Purpose: carries the frame-sampled color bytes to the pattern selector
// Assumes: single clock
// Notes: none
`timescale 1ns/10ps
interface color_if;
   logic [7:0] snap [9];   // bytes as latched at frame start
   modport src (output snap);
   modport dst (input  snap);
endinterface

// *** core/pattern_sel.sv ***
// Purpose: picks the pattern byte from the frame-latched color bytes
// Assumes: bar_idx and fixed_idx come from the pattern timing logic
// Notes: ninth byte is reachable only in fixed mode
`timescale 1ns/10ps
module pattern_sel (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // frame-latched bytes
   color_if.dst                         cin,
   // selection
   input  wire color_bytes_pkg::pat_mode_t mode,
   input  wire logic [2:0]              bar_idx,
   input  wire logic [3:0]              fixed_idx,
   // chosen byte
   output logic [7:0]                   pix_q
);
   import color_bytes_pkg::*;
   logic [7:0] bar_byte;
   logic [7:0] fix_byte;
   logic [7:0] pix_d;
   // bar index covers only the first eight bytes
   assign bar_byte = cin.snap[bar_idx];
   // fixed index 0..8 walks bytes in ascending order
   assign fix_byte = (fixed_idx < 4'(NUM_REGS)) ?
                     cin.snap[fixed_idx] : 8'h00;
   assign pix_d = (mode == MODE_BARS)  ? bar_byte :
                  (mode == MODE_FIXED) ? fix_byte : 8'h00;
   // register the output byte
   always_ff @(posedge clk) begin
      if (!rst_n) pix_q <= 8'h00;
      else        pix_q <= pix_d;
   end
   // sampled rst_n keeps the reset-release edge out of the antecedent
   chk_bar_value: assert property (
      @(posedge clk) disable iff (!rst_n)
      rst_n && mode == MODE_BARS
      |=> pix_q == $past(cin.snap[bar_idx]))
      else $error("bar byte mismatch");
   chk_fixed_value: assert property (
      @(posedge clk) disable iff (!rst_n)
      rst_n && mode == MODE_FIXED && fixed_idx == 4'h8
      |=> pix_q == $past(cin.snap[8]))
      else $error("ninth fixed byte mismatch");
endmodule // pattern_sel

// *** core/color_bytes_regs.sv ***
// Purpose: nine read/write color bytes feeding the test pattern generator
// Assumes: Avalon-MM slave, word address = byte address / 4
// Notes: bytes are copied to the generator at each frame start
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/10ps
module color_bytes_regs (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   // avalon-mm slave
   input  wire logic [7:0]                 avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [31:0]                avs_writedata,
   input  wire logic [3:0]                 avs_byteenable,
   output logic [31:0]                     avs_readdata,
   output logic                            avs_waitrequest,
   // pattern generator side
   input  wire logic                       frame_start,
   input  wire color_bytes_pkg::pat_mode_t mode,
   input  wire logic [2:0]                 bar_idx,
   input  wire logic [3:0]                 fixed_idx,
   output logic [7:0]                      pix_q
);
   import color_bytes_pkg::*;

   logic [7:0] regs_q [NUM_REGS];
   logic [7:0] wr_byte;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic        ack_q;
   logic        wait_q;
   logic        hit;
   logic [3:0]  sel;
   logic        req;
   color_if     cbus ();

   // word index decode; registers 0x10..0x18
   assign hit = (avs_address >= IDX_BAR0) && (avs_address <= IDX_BYTE9);
   assign sel = 4'(avs_address - IDX_BAR0);
   assign req = (avs_read || avs_write) && !ack_q;
   assign wr_byte = avs_writedata[7:0];
   // unmapped reads return zero, reserved upper bits read zero
   assign rdata_d = hit ? {24'h0, regs_q[sel]} : 32'h0;

   // one wait cycle then an acknowledge cycle
   always_ff @(posedge clk) begin
      if (!rst_n) ack_q <= 1'b0;
      else        ack_q <= req;
   end

   // waitrequest from its own flop, always the inverse of the ack flop
   always_ff @(posedge clk) begin
      if (!rst_n) wait_q <= 1'b1;
      else        wait_q <= !req;
   end
   assign avs_waitrequest = wait_q;

   // read data captured while waiting
   always_ff @(posedge clk) begin
      if (!rst_n) rdata_q <= 32'h0;
      else if (avs_read && !ack_q) rdata_q <= rdata_d;
   end
   assign avs_readdata = rdata_q;

   // register storage with per-register reset values
   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : g_reg
         always_ff @(posedge clk) begin
            if (!rst_n)
               regs_q[g] <= RST_VAL[g];
            else if (avs_write && ack_q && hit && sel == 4'(g)
                     && avs_byteenable[0])
               regs_q[g] <= wr_byte;
         end
         // frame-boundary copy for the generator
         always_ff @(posedge clk) begin
            if (!rst_n)
               cbus.snap[g] <= RST_VAL[g];
            else if (frame_start)
               cbus.snap[g] <= regs_q[g];
         end
      end
   endgenerate

   pattern_sel pattern_sel_i (
      .clk       (clk),
      .rst_n     (rst_n),
      .cin       (cbus),
      .mode      (mode),
      .bar_idx   (bar_idx),
      .fixed_idx (fixed_idx),
      .pix_q     (pix_q)
   );

   // written low byte is stored in the addressed register
   chk_write_back: assert property (
      @(posedge clk) disable iff (!rst_n)
      avs_write && ack_q && hit && avs_byteenable[0]
      |=> regs_q[$past(sel)] == $past(wr_byte))
      else $error("write not stored");
   // the first snapshot byte only moves at a frame start
   chk_hold_frame: assert property (
      @(posedge clk) disable iff (!rst_n)
      !frame_start |=> cbus.snap[0] == $past(cbus.snap[0]))
      else $error("snapshot moved mid frame");
   // each request is acknowledged after exactly one wait cycle
   chk_wait_one: assert property (
      @(posedge clk) disable iff (!rst_n)
      req |=> !avs_waitrequest)
      else $error("no acknowledge after one cycle");
   // read handshake: request seen while waiting, answered next cycle
   sequence rd_wait_s;
      avs_read && avs_waitrequest;
   endsequence
   sequence rd_ack_s;
      !avs_waitrequest && avs_readdata[31:8] == 24'h0;
   endsequence
   chk_read_upper: assert property (
      @(posedge clk) disable iff (!rst_n)
      rd_wait_s |=> rd_ack_s)
      else $error("read not answered with upper bits clear");
   chk_read_unmapped: assert property (
      @(posedge clk) disable iff (!rst_n)
      rd_wait_s ##0 !hit |=> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
endmodule // color_bytes_regs

// *** test/color_bytes_regs_test.sv ***
// Purpose: self-checking bench for the color byte bank and pattern select
// Assumes: one idle cycle between bus requests; pix_q lags index by one
// Notes: random bytes and lane enables come from a fixed-seed xorshift
`timescale 1ns/10ps
module color_bytes_regs_test;
   import color_bytes_pkg::*;
   logic        clk, rst_n, avs_read, avs_write, avs_waitrequest;
   logic        frame_start;
   logic [7:0]  avs_address, pix_q;
   logic [31:0] avs_writedata, avs_readdata, rd, seed;
   logic [3:0]  avs_byteenable, fixed_idx;
   logic [2:0]  bar_idx;
   pat_mode_t   mode;
   logic [7:0]  regs_q [9];
   logic [7:0]  snap_q [9];
   int          n_errors, comparisons, i, r;
   color_bytes_regs color_bytes_regs_i (.clk(clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .frame_start(frame_start),
      .mode(mode), .bar_idx(bar_idx), .fixed_idx(fixed_idx),
      .pix_q(pix_q));
   // xorshift source, repeatable from its fixed seed
   function automatic logic [31:0] next_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // byte the generator should show for a mode and index
   function automatic logic [7:0] want(pat_mode_t m, int k);
      if (m == MODE_BARS) return snap_q[k % 8];
      if (m == MODE_FIXED && k < 9) return snap_q[k];
      return 8'h00;
   endfunction
   task automatic end_of_test;
      $display("n_errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      int k;
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (k == 20) begin
         n_errors++;
         end_of_test();
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   // every mode against every index, ninth byte included
   task automatic sweep;
      for (int m = 0; m < 3; m++) begin
         for (int k = 0; k < 16; k++) begin
            mode <= pat_mode_t'(m);
            bar_idx <= k[2:0];
            fixed_idx <= k[3:0];
            @(posedge clk);
            @(posedge clk);
            check(pix_q, want(pat_mode_t'(m), k));
         end
      end
   endtask
   task automatic frame;
      frame_start <= 1'b1;
      @(posedge clk);
      frame_start <= 1'b0;
      snap_q = regs_q;
   endtask
   // clock generation
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // main sequence
   initial begin
      {rst_n, avs_read, avs_write, frame_start} = 4'h0;
      {avs_address, avs_writedata, avs_byteenable} = '0;
      mode = MODE_OFF;
      {bar_idx, fixed_idx} = '0;
      seed = 32'hb0d885c1;
      n_errors = 0;
      comparisons = 0;
      regs_q = RST_VAL;
      snap_q = RST_VAL;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 9; i++) begin
         bus(1'b0, IDX_BAR0 + 8'(i), 32'h0, 4'hf);
         check(rd, {24'h0, RST_VAL[i]});
      end
      sweep();
      for (r = 0; r < 3; r++) begin
         for (i = 0; i < 9; i++) begin
            rd = next_rand();
            bus(1'b1, IDX_BAR0 + 8'(i), rd, seed[3:0]);
            // rd now holds read data; seed still holds the written word
            if (seed[0]) regs_q[i] = seed[7:0];
         end
         // unmapped write whose low index bits alias the first byte
         bus(1'b1, 8'h20, 32'hff, 4'hf);
         for (i = 0; i < 9; i++) begin
            bus(1'b0, IDX_BAR0 + 8'(i), 32'h0, 4'hf);
            check(rd, {24'h0, regs_q[i]});
         end
         bus(1'b0, 8'h19, 32'h0, 4'hf);
         check(rd, 32'h0);
         sweep();
         frame();
         sweep();
      end
      // reset in mid-run brings every byte and the snapshot back
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      regs_q = RST_VAL;
      snap_q = RST_VAL;
      for (i = 0; i < 9; i++) begin
         bus(1'b0, IDX_BAR0 + 8'(i), 32'h0, 4'hf);
         check(rd, {24'h0, regs_q[i]});
      end
      sweep();
      end_of_test();
   end
endmodule // color_bytes_regs_test
